/* File: src/cmd_map.vh */
// Constants for the three-byte control message decoder
`ifndef CMD_MAP_VH
`define CMD_MAP_VH
// Address class boundaries
`define CMD_ADDR_INDIV_TOP   2'h0
`define CMD_ADDR_ORIG_TOP    2'h1
`define CMD_ADDR_TYPE_TOP    2'h2
`define CMD_ADDR_GROUP_TOP   3'h6
`define CMD_ADDR_RSVD_TOP    3'h7
`define CMD_ADDR_BCAST       8'hFF
// Command space boundaries
`define CMD_COMMON_TOP       1'h0
`define CMD_TYPESPEC_TOP     2'h2
`define CMD_MFR_TOP          2'h3
// Opcodes
`define CMD_DATALESS         8'h7F
`define CMD_OP_ENABLE_MFR    8'h10
`define CMD_OP_DISABLE_MFR   8'h11
`define CMD_OP_QUERY_TYPE    8'h12
`define CMD_OP_QUERY_MFR_EN  8'h13
`define CMD_OP_SET_GROUP_LO  8'h01
`define CMD_OP_SET_GROUP_HI  8'h02
`define CMD_OP_MFR_ID_READ   8'hC0
`define CMD_OP_TYPE_QUERY    8'h80
// Reply values
`define CMD_YES              8'hFF
// Device type range
`define CMD_TYPE_FIRST       8'h80
`define CMD_TYPE_LAST        8'h8C
// Identification store
`define CMD_ID_DEPTH         16
`define CMD_ID_AW            4
// Reset values
`define CMD_RST_BYTE         8'h00
`define CMD_RST_GROUP        32'h00000000
`endif

/* File: src/cmd_id_rom.v */
// Read-only identification store with registered read data
`timescale 1ns/1ns
module cmd_id_rom
(
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire [3:0] addr,
    output reg  [7:0] rdata
);
`include "cmd_map.vh"
    // Arbitrary neutral identification content, sixteen bytes
    parameter [127:0] ID_CONTENT = 128'h0F0E0D0C0B0A09080706050403020100;

    // Registered read; no side effects on reads
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= `CMD_RST_BYTE;
        else
            rdata <= ID_CONTENT[{addr, 3'h0} +: 8]; // R18
    end
endmodule

/* File: src/cmd_addr_class.v */
// Address byte classifier and membership match
`timescale 1ns/1ns
module cmd_addr_class
(
    input  wire [7:0]  addr_byte,
    input  wire [5:0]  own_addr,
    input  wire [7:0]  own_type,
    input  wire [31:0] groups,
    output wire        is_indiv,
    output wire        is_orig,
    output wire        is_type,
    output wire        is_group,
    output wire        is_rsvd,
    output wire        is_bcast,
    output wire        hit
);
`include "cmd_map.vh"
    // Class from top bits
    assign is_indiv = (addr_byte[7:6] == `CMD_ADDR_INDIV_TOP); // R1
    assign is_orig  = (addr_byte[7:6] == `CMD_ADDR_ORIG_TOP);  // R2
    assign is_type  = (addr_byte[7:6] == `CMD_ADDR_TYPE_TOP);  // R3
    assign is_group = (addr_byte[7:5] == `CMD_ADDR_GROUP_TOP); // R4
    assign is_bcast = (addr_byte == `CMD_ADDR_BCAST);          // R6
    assign is_rsvd  = (addr_byte[7:5] == `CMD_ADDR_RSVD_TOP) && !is_bcast; // R5

    // Membership: originator messages are heard by all, reserved never
    assign hit = (is_indiv && (addr_byte[5:0] == own_addr))
               || is_orig
               || (is_type && (addr_byte == own_type)) // R19
               || (is_group && groups[addr_byte[4:0]])
               || is_bcast; // R22
endmodule

/* File: src/cmd_decoder.v */
// Three-byte control message decoder: addressing, command spaces, replies
//
// Function
// [R1] Top two address bits zero: individual address in low six bits.
// [R2] Address bits 01: originator address of the sender.
// [R3] Address bits 10: type address in low six bits.
// [R4] Address bits 110: group address in low five bits.
// [R5] Addresses 224 to 254 are reserved, not broadcast.
// [R6] Address 255 is broadcast, received by every device.
// [R7] Commands split: common, type-specific, manufacturer-specific ranges.
// [R8] Data commands: second byte opcode, third byte argument.
// [R9] Data-less indicator moves the opcode into the third byte.
// [R10] Common commands always served; undefined common codes are reserved.
// [R11] A query normally answers with one eight-bit value.
// [R12] Yes/no query: all ones for yes, no reply for no.
// [R13] Type-specific codes are interpreted by own device type.
// [R14] After reset manufacturer commands ignored except identification query.
// [R15] Manufacturer commands honoured only after individual enabling command.
// [R16] Identification read returns at least sixteen bytes.
// [R17] Identification read works whether manufacturer commands enabled or not.
// [R18] Identification fields read only, reading has no side effect.
// [R19] Own type code serves as type address; 0x80 to 0x8C defined.
// [R20] Manufacturer output should avoid broadcast addressing.
// [R21] Multi-type devices hold one individual address per type.
// [R22] Reserved or unmatched addresses are dropped without response.
`timescale 1ns/1ns
module cmd_decoder
(
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        msg_valid,
    input  wire [7:0]  msg_addr,
    input  wire [7:0]  msg_cmd,
    input  wire [7:0]  msg_data,
    input  wire [5:0]  own_addr,
    input  wire [7:0]  own_type,
    input  wire        reply_ready,
    output wire        reply_valid,
    output reg  [7:0]  reply_data,
    output reg         mfr_enabled,
    output reg         exec_valid,
    output reg  [1:0]  exec_space,
    output reg  [7:0]  exec_opcode,
    output reg  [7:0]  exec_arg,
    output reg         exec_dataless,
    output reg  [2:0]  addr_class,
    output reg         msg_dropped,
    output reg  [31:0] group_member
);
`include "cmd_map.vh"

    // ------------------------------------------------------------
    // Interface summary
    // ------------------------------------------------------------
    // msg_valid strobes all three message bytes in a single cycle.
    // exec_valid and msg_dropped are one-cycle registered pulses; the other exec_* hold until the next take.
    // reply_valid stands until reply_ready; new messages are refused meanwhile.
    // mfr_enabled and group_member are kept state, cleared by reset, CMD_OP_DISABLE_MFR and CMD_OP_SET_GROUP_LO.
    // The sender must leave a reply time to drain before the next message,
    // otherwise that message is dropped rather than queued.
    // Own address and type are levels and are expected to be quiet in use.

    // ------------------------------------------------------------
    // Local encodings
    // ------------------------------------------------------------
    localparam [1:0] SP_COMMON = 2'h0;
    localparam [1:0] SP_TYPE   = 2'h1;
    localparam [1:0] SP_MFR    = 2'h2;

    localparam [2:0] CL_INDIV = 3'h0;
    localparam [2:0] CL_ORIG  = 3'h1;
    localparam [2:0] CL_TYPE  = 3'h2;
    localparam [2:0] CL_GROUP = 3'h3;
    localparam [2:0] CL_RSVD  = 3'h4;
    localparam [2:0] CL_BCAST = 3'h5;

    // One-hot states of the reply engine
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_ROM   = 3'h2;
    localparam [2:0] ST_REPLY = 3'h4;

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    wire is_indiv;
    wire is_orig;
    wire is_type;
    wire is_group;
    wire is_rsvd;
    wire is_bcast;
    wire addr_hit;

    cmd_addr_class u_class
    (
        .addr_byte (msg_addr),
        .own_addr  (own_addr),
        .own_type  (own_type),
        .groups    (group_member),
        .is_indiv  (is_indiv),
        .is_orig   (is_orig),
        .is_type   (is_type),
        .is_group  (is_group),
        .is_rsvd   (is_rsvd),
        .is_bcast  (is_bcast),
        .hit       (addr_hit)
    );

    // Own type outside the defined list refuses type-specific commands
    wire type_known = (own_type >= `CMD_TYPE_FIRST) && (own_type <= `CMD_TYPE_LAST); // R19

    // One individual address per instance; a multi-type device uses one per type
    wire to_me = is_indiv && (msg_addr[5:0] == own_addr); // R15 R21

    // ------------------------------------------------------------
    // Command decoding
    // ------------------------------------------------------------
    // Data-less indicator pulls the real opcode from the third byte
    wire       dataless = (msg_cmd == `CMD_DATALESS);                 // R9
    wire [7:0] opcode   = dataless ? msg_data : msg_cmd;              // R8 R9
    wire [7:0] argument = dataless ? `CMD_RST_BYTE : msg_data;        // R8

    // Space is taken from the effective opcode
    wire sp_common = (opcode[7] == `CMD_COMMON_TOP);                  // R7
    wire sp_type   = (opcode[7:6] == `CMD_TYPESPEC_TOP);              // R7
    wire sp_mfr    = (opcode[7:6] == `CMD_MFR_TOP);                   // R7

    // Identification read passes the manufacturer gate
    wire is_id_read = sp_mfr && (opcode == `CMD_OP_MFR_ID_READ);      // R16 R17

    // Originator messages carry sensor data, not commands for us
    wire accept = msg_valid && addr_hit && !is_rsvd && !is_orig;      // R22

    // Manufacturer commands gated by enable; the read always passes
    wire mfr_ok = mfr_enabled || is_id_read;                          // R14 R15 R17

    // Type-specific commands only mean something for a known own type
    wire type_ok = type_known;                                        // R13

    // Each space has its own permit; the common space is always open
    wire space_ok = sp_common || (sp_type && type_ok) || (sp_mfr && mfr_ok); // R10 R13 R14
    wire run_cmd  = accept && space_ok;

    // ------------------------------------------------------------
    // Reply engine and identification store
    // ------------------------------------------------------------
    // Timing seen from the bus side:
    //   query taken on edge 0, reply byte standing from edge 0
    //   identification read taken on edge 0, store read on that same edge,
    //   byte copied into reply_data on edge 1, standing from edge 1 on
    //   the byte stands until the transmitter shows ready
    //   the store is addressed early because its read data are registered
    reg  [2:0] state;
    reg  [2:0] next_state;
    reg  [3:0] id_index;
    wire [7:0] id_byte;
    wire [3:0] rom_addr;
    reg        query_reply;
    reg  [7:0] query_value;

    cmd_id_rom u_rom
    (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .addr    (rom_addr),
        .rdata   (id_byte)
    );

    // Replies carry no address, so manufacturer data go only to the asker
    assign reply_valid = (state == ST_REPLY); // R20

    // Reply handshake completes on valid and ready together
    wire reply_done = reply_valid && reply_ready;

    // New messages are only taken when no reply is pending
    wire take = run_cmd && (state == ST_IDLE);

    // Present the new index on the taking edge so the byte is ready one edge later
    assign rom_addr = (take && is_id_read) ? argument[3:0] : id_index; // R16

    // Next state
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (take && is_id_read)
                    next_state = ST_ROM;
                else if (take && query_reply)
                    next_state = ST_REPLY;
            ST_ROM:
                next_state = ST_REPLY;
            ST_REPLY:
                if (reply_done)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Query answers
    // ------------------------------------------------------------
    // Yes/no: yes is all ones, no sends nothing at all
    always @*
    begin
        query_reply = 1'b0;
        query_value = `CMD_RST_BYTE;
        if (sp_common && dataless)
        begin
            case (opcode)
                `CMD_OP_QUERY_TYPE:
                begin
                    query_reply = 1'b1;                               // R11
                    query_value = own_type;
                end
                `CMD_OP_QUERY_MFR_EN:
                begin
                    query_reply = mfr_enabled;                        // R12
                    query_value = `CMD_YES;                           // R12
                end
                default:
                begin
                    query_reply = 1'b0;                               // R10
                    query_value = `CMD_RST_BYTE;
                end
            endcase
        end
        else if (sp_type && dataless && opcode == `CMD_OP_TYPE_QUERY)
        begin
            query_reply = 1'b1;                                       // R13
            query_value = own_type;
        end
    end

    // State and identification index
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state    <= ST_IDLE;
            id_index <= 4'h0;
        end
        else
        begin
            state <= next_state;
            // Argument low nibble selects the byte; sixteen bytes present
            if (take && is_id_read)
                id_index <= argument[3:0];                            // R16
        end
    end

    // Reply data register
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            reply_data <= `CMD_RST_BYTE;
        else if (state == ST_ROM)
            reply_data <= id_byte;                                    // R16 R18
        else if (take && query_reply && !is_id_read)
            reply_data <= query_value;                                // R11 R12
    end

    // ------------------------------------------------------------
    // Configuration state
    // ------------------------------------------------------------
    // Enabling must come individually addressed; broadcast cannot enable
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            mfr_enabled <= 1'b0;                                      // R14
        else if (take && to_me && sp_common && dataless && opcode == `CMD_OP_ENABLE_MFR)
            mfr_enabled <= 1'b1;                                      // R15
        else if (take && sp_common && dataless && opcode == `CMD_OP_DISABLE_MFR)
            mfr_enabled <= 1'b0;
    end

    // Group membership set by data commands, five-bit group index in argument
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            group_member <= `CMD_RST_GROUP;
        else if (take && sp_common && !dataless && opcode == `CMD_OP_SET_GROUP_LO)
            group_member[argument[4:0]] <= 1'b0;                      // R8
        else if (take && sp_common && !dataless && opcode == `CMD_OP_SET_GROUP_HI)
            group_member[argument[4:0]] <= 1'b1;                      // R8
    end

    // ------------------------------------------------------------
    // Executed command output to the device-specific logic
    // ------------------------------------------------------------
    // Identification read is handled here and not passed on
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            exec_valid    <= 1'b0;
            exec_space    <= SP_COMMON;
            exec_opcode   <= `CMD_RST_BYTE;
            exec_arg      <= `CMD_RST_BYTE;
            exec_dataless <= 1'b0;
        end
        else
        begin
            exec_valid <= take && !is_id_read;                        // R7 R10
            if (take)
            begin
                exec_space    <= sp_mfr ? SP_MFR : (sp_type ? SP_TYPE : SP_COMMON); // R7 R13
                exec_opcode   <= opcode;                              // R8 R9
                exec_arg      <= argument;                            // R8
                exec_dataless <= dataless;                            // R9
            end
        end
    end

    // ------------------------------------------------------------
    // Address class report and drop flag
    // ------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_class  <= CL_INDIV;
            msg_dropped <= 1'b0;
        end
        else
        begin
            msg_dropped <= msg_valid && !take;                        // R22
            if (msg_valid)
            begin
                if (is_bcast)
                    addr_class <= CL_BCAST;                           // R6
                else if (is_rsvd)
                    addr_class <= CL_RSVD;                            // R5
                else if (is_group)
                    addr_class <= CL_GROUP;                           // R4
                else if (is_type)
                    addr_class <= CL_TYPE;                            // R3
                else if (is_orig)
                    addr_class <= CL_ORIG;                            // R2
                else
                    addr_class <= CL_INDIV;                           // R1
            end
        end
    end
endmodule

/* File: sim/cmd_decoder_checker.sv */
// Port-level assertions for the control message decoder
`timescale 1ns/1ns
module cmd_decoder_checker
(
    input wire        clk_sys,
    input wire        rst_b,
    input wire        msg_valid,
    input wire [7:0]  msg_addr,
    input wire [7:0]  msg_cmd,
    input wire [7:0]  msg_data,
    input wire [5:0]  own_addr,
    input wire        reply_ready,
    input wire        reply_valid,
    input wire [7:0]  reply_data,
    input wire        mfr_enabled,
    input wire        exec_valid,
    input wire [1:0]  exec_space,
    input wire [7:0]  exec_opcode,
    input wire [7:0]  exec_arg,
    input wire        exec_dataless,
    input wire [2:0]  addr_class,
    input wire        msg_dropped
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Address handling, command spaces and reply hold
    // ----------------------------------------
    a_drop_or_exec: assert property (!(exec_valid && msg_dropped))
        else $error("exec and drop together");
    a_reply_holds: assert property (reply_valid && !reply_ready |=>
        reply_valid && $stable(reply_data)) else $error("reply not held");
    a_exec_cause: assert property (exec_valid |->
        $past(msg_valid) || $past(msg_valid, 2)) else $error("exec without message");
    a_rsvd_drop: assert property (msg_valid && !reply_valid && msg_addr[7:5] == 3'h7
        && msg_addr != 8'hFF |=> msg_dropped && addr_class == 3'h4)
        else $error("reserved address taken");
    a_orig_drop: assert property (msg_valid && !reply_valid && msg_addr[7:6] == 2'h1
        |=> msg_dropped && addr_class == 3'h1) else $error("originator taken");
    a_bcast_class: assert property (msg_valid && !reply_valid && msg_addr == 8'hFF
        && !msg_cmd[7] && !(msg_cmd == 8'h7F && msg_data[7])
        |=> addr_class == 3'h5 && !msg_dropped) else $error("broadcast refused");
    a_mfr_gate: assert property (msg_valid && msg_cmd[7:6] == 2'h3
        && msg_cmd != 8'hC0 && !mfr_enabled |=> !exec_valid) else $error("mfr not gated");
    a_mfr_rise: assert property ($rose(mfr_enabled) |-> $past(msg_valid)
        && $past(msg_cmd) == 8'h7F && $past(msg_data) == 8'h10
        && $past(msg_addr) == {2'h0, own_addr}) else $error("mfr enable cause");
    a_space_map: assert property ((msg_valid && msg_cmd != 8'h7F) ##1 exec_valid |->
        exec_space == ($past(msg_cmd[7]) ? ($past(msg_cmd[6]) ? 2'h2 : 2'h1) : 2'h0))
        else $error("command space wrong");
    a_dataless_op: assert property ((msg_valid && msg_cmd == 8'h7F) ##1 exec_valid
        |-> exec_dataless && exec_opcode == $past(msg_data) && exec_arg == 8'h00)
        else $error("dataless opcode wrong");
    a_data_op: assert property ((msg_valid && msg_cmd != 8'h7F) ##1 exec_valid |->
        exec_opcode == $past(msg_cmd) && exec_arg == $past(msg_data))
        else $error("data command wrong");
endmodule

bind cmd_decoder cmd_decoder_checker u_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .msg_valid(msg_valid), .msg_addr(msg_addr),
    .msg_cmd(msg_cmd), .msg_data(msg_data), .own_addr(own_addr),
    .reply_ready(reply_ready), .reply_valid(reply_valid), .reply_data(reply_data),
    .mfr_enabled(mfr_enabled), .exec_valid(exec_valid), .exec_space(exec_space),
    .exec_opcode(exec_opcode), .exec_arg(exec_arg), .exec_dataless(exec_dataless),
    .addr_class(addr_class), .msg_dropped(msg_dropped));

/* File: sim/cmd_reply_sink.sv */
// Far-side receiver of reply bytes with prompt, random or stalled acceptance
`timescale 1ns/1ns
module cmd_reply_sink
(
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire [1:0] mode,
    input  wire       reply_valid,
    input  wire [7:0] reply_data,
    output reg        reply_ready,
    output reg  [7:0] n_got,
    output reg  [7:0] got_byte
);
    integer seed = 95;
    initial reply_ready = 1'b0;
    // Mode 0 always ready, 1 random stalls, 2 holds off to keep a reply pending
    always @(negedge clk_sys)
        reply_ready <= (mode == 2'h0) || (mode == 2'h1 && $random(seed) % 2 == 0);
    // A byte is taken only on an edge that sees both valid and ready
    always @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            n_got <= 8'h00;
        else if (reply_valid && reply_ready)
        begin
            n_got    <= n_got + 8'h01;
            got_byte <= reply_data;
        end
endmodule

/* File: sim/cmd_decoder_tb_top.sv */
// Self-checking bench for the control message decoder
`timescale 1ns/1ns
`include "cmd_map.vh"
`define TB_CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
    n_mismatch = n_mismatch + 1; \
    $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module cmd_decoder_tb_top;
    reg          clk_sys;
    reg          rst_b;
    reg          msg_valid;
    reg  [7:0]   msg_addr;
    reg  [7:0]   msg_cmd;
    reg  [7:0]   msg_data;
    reg  [5:0]   own_addr;
    reg  [7:0]   own_type;
    reg  [1:0]   mode;
    reg  [7:0]   a;
    reg  [7:0]   c;
    reg  [31:0]  r;
    wire [7:0]   own = {2'h0, own_addr};
    wire         reply_ready;
    wire         reply_valid;
    wire [7:0]   reply_data;
    wire         mfr_enabled;
    wire         exec_valid;
    wire [1:0]   exec_space;
    wire [7:0]   exec_opcode;
    wire [7:0]   exec_arg;
    wire         exec_dataless;
    wire [2:0]   addr_class;
    wire         msg_dropped;
    wire [31:0]  group_member;
    wire [7:0]   n_got;
    wire [7:0]   got_byte;
    integer      seed;
    integer      n_mismatch;
    integer      n_tests;
    integer      i;

    cmd_decoder u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .msg_valid(msg_valid),
        .msg_addr(msg_addr), .msg_cmd(msg_cmd), .msg_data(msg_data), .own_addr(own_addr),
        .own_type(own_type), .reply_ready(reply_ready), .reply_valid(reply_valid),
        .reply_data(reply_data), .mfr_enabled(mfr_enabled), .exec_valid(exec_valid),
        .exec_space(exec_space), .exec_opcode(exec_opcode), .exec_arg(exec_arg),
        .exec_dataless(exec_dataless), .addr_class(addr_class),
        .msg_dropped(msg_dropped), .group_member(group_member));
    cmd_reply_sink u_sink (.clk_sys(clk_sys), .rst_b(rst_b), .mode(mode),
        .reply_valid(reply_valid), .reply_data(reply_data), .reply_ready(reply_ready),
        .n_got(n_got), .got_byte(got_byte));

    // 20 MHz clock
    always #25 clk_sys = ~clk_sys;

    // ----------------------------------------
    // Expectations and drivers
    // ----------------------------------------
    function [2:0] class_of(input [7:0] x);
        if (x == 8'hFF) class_of = 3'h5;
        else if (x[7:5] == 3'h7) class_of = 3'h4;
        else class_of = {1'b0, x[7:6]};
    endfunction
    function [1:0] space_of(input [7:0] x);
        space_of = x[7] ? (x[6] ? 2'h2 : 2'h1) : 2'h0;
    endfunction
    // One-cycle message pulse; outputs of the taking edge are settled on return
    task send(input [7:0] ta, input [7:0] tc, input [7:0] td);
        begin
            @(negedge clk_sys);
            msg_valid = 1'b1;
            msg_addr  = ta;
            msg_cmd   = tc;
            msg_data  = td;
            @(negedge clk_sys);
            msg_valid = 1'b0;
        end
    endtask
    // Bounded wait for the sink to take one reply byte
    task take_reply(input [7:0] exp);
        reg [7:0] old;
        begin
            old = n_got;
            repeat (40) if (n_got == old) @(negedge clk_sys);
            `TB_CHK(n_got, old + 8'h01)
            `TB_CHK(got_byte, exp)
        end
    endtask
    task tally_and_finish;
        begin
            $display("tests %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    // Watchdog well beyond the expected run of about 250 cycles
    initial
    begin
        #250000;
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
    end

    // Main sequence: corner cases first, random traffic last
    initial
    begin
        {clk_sys, rst_b, msg_valid, msg_addr, msg_cmd, msg_data} = 27'h0;
        own_addr = 6'h15;
        own_type = 8'h83;
        mode = 2'h0;
        seed = 95;
        n_mismatch = 0;
        n_tests = 0;
        repeat (5) @(negedge clk_sys);
        rst_b = 1'b1;
        send(own, `CMD_DATALESS, `CMD_OP_QUERY_TYPE);
        `TB_CHK({exec_valid, exec_dataless, exec_opcode}, {2'h3, 8'h12})
        take_reply(own_type);
        `TB_CHK(mfr_enabled, 1'b0)
        send(own, 8'hC5, 8'hAA);
        `TB_CHK({exec_valid, msg_dropped}, 2'h1)
        send(own, `CMD_DATALESS, `CMD_OP_QUERY_MFR_EN);
        repeat (4) @(negedge clk_sys);
        `TB_CHK(reply_valid, 1'b0)
        send(own, `CMD_OP_MFR_ID_READ, 8'h03);
        take_reply(8'h03);
        `TB_CHK(mfr_enabled, 1'b0)
        send(8'hFF, `CMD_DATALESS, `CMD_OP_ENABLE_MFR);
        `TB_CHK(mfr_enabled, 1'b0)
        send(own, `CMD_DATALESS, `CMD_OP_ENABLE_MFR);
        `TB_CHK(mfr_enabled, 1'b1)
        send(own, `CMD_DATALESS, `CMD_OP_QUERY_MFR_EN);
        take_reply(`CMD_YES);
        send(own, 8'hC5, 8'hAA);
        `TB_CHK({exec_valid, exec_space, exec_opcode, exec_arg}, 19'h6C5AA)
        send(own, `CMD_OP_MFR_ID_READ, 8'h1F);
        take_reply(8'h0F);
        send(own_type, 8'h80, 8'h55);
        `TB_CHK({exec_valid, exec_space}, 3'h5)
        send(8'h84, 8'h80, 8'h55);
        `TB_CHK({exec_valid, msg_dropped}, 2'h1)
        own_type = 8'h90;
        send(8'h90, 8'h80, 8'h55);
        `TB_CHK(msg_dropped, 1'b1)
        own_type = 8'h83;
        send(own, `CMD_OP_SET_GROUP_HI, 8'h07);
        `TB_CHK(group_member[7], 1'b1)
        send(8'hC7, 8'h05, 8'h01);
        `TB_CHK(exec_valid, 1'b1)
        send(8'hC8, 8'h05, 8'h01);
        `TB_CHK(msg_dropped, 1'b1)
        send(8'hFF, 8'h05, 8'h00);
        `TB_CHK(exec_valid, 1'b1)
        for (i = 0; i < 2; i = i + 1)
        begin
            send(i ? 8'hFE : 8'hE0, 8'h05, 8'h00);
            `TB_CHK({msg_dropped, addr_class}, 4'hC)
        end
        // A second message while the reply waits must be refused
        mode = 2'h2;
        send(own, `CMD_DATALESS, `CMD_OP_QUERY_TYPE);
        send(own, 8'h05, 8'h00);
        `TB_CHK(msg_dropped, 1'b1)
        mode = 2'h1;
        take_reply(own_type);
        rst_b = 1'b0;
        @(negedge clk_sys);
        rst_b = 1'b1;
        `TB_CHK({mfr_enabled, group_member[7]}, 2'h0)
        for (i = 0; i < 60; i = i + 1)
        begin
            r = $random(seed);
            mode = {1'b0, r[0]};
            case (r[3:2])
                2'h0: a = own;
                2'h1: a = own_type;
                2'h2: a = 8'hFF;
                default: a = r[15:8];
            endcase
            r = $random(seed);
            c = r[7:0];
            send(a, c, r[15:8]);
            `TB_CHK(addr_class, class_of(a))
            if (exec_valid === 1'b1 && c != `CMD_DATALESS)
                `TB_CHK(exec_space, space_of(c))
            @(negedge clk_sys);
            repeat (40) if (reply_valid) @(negedge clk_sys);
        end
        tally_and_finish;
    end
endmodule
